// ### hw/ssg_gate.sv
/*
 Spindle stop and ready gate with AXI4-Lite registers.
 Assumes controller command pins are synchronous to aclk.
*/
`timescale 1ns/100ps
`default_nettype none
module ssg_gate #(
   parameter int unsigned ORIENT_CYC = ssg_pkg::ORIENT_CYC,
   parameter int unsigned TICK_DIV   = ssg_pkg::RAMP_TICK_CYC
) (
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [31:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [31:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        emergency_stop_n,
   input  wire logic        machine_ready,
   input  wire logic        orientation_command,
   input  wire logic        rotate_fwd,
   input  wire logic        rotate_rev,
   output logic             contactor_off,
   output logic             excitation,
   output logic             orient_hold,
   output logic             orient_done,
   output logic [15:0]      motor_speed
);
   if (ORIENT_CYC < 1 || ORIENT_CYC > 65535) begin : g_bad_orient
      $error("ssg_gate: ORIENT_CYC out of range");
   end

   ////////////////////////////////////////////////////////////////////////
   // Registers and bus state
   logic               ready_mode_q;
   logic [15:0]        speed_cmd_q;
   logic               aw_have_q;
   logic               w_have_q;
   logic [3:0]         waddr_q;
   logic [31:0]        wdata_q;
   logic [3:0]         wstrb_q;
   ssg_pkg::ssg_state_t st_q;
   ssg_pkg::ssg_state_t st_d;
   logic               orient_busy_q;
   logic [15:0]        orient_cnt_q;
   logic               tick;
   logic [15:0]        target;
   logic               gate_ok;
   logic               operable;
   logic               speed_zero;

   function automatic logic mapped(input logic [3:0] a);
      mapped = (a == ssg_pkg::REG_CTRL) || (a == ssg_pkg::REG_SPEED_CMD) ||
               (a == ssg_pkg::REG_STATUS) || (a == ssg_pkg::REG_SPEED);
   endfunction

   function automatic logic word_addr_ok(input logic [31:0] a);
      word_addr_ok = (a[31:4] == 28'h0000000) && mapped(a[3:0]);
   endfunction

   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite write channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_awready <= 1'b0;
         aw_have_q     <= 1'b0;
         waddr_q       <= 4'h0;
      end else if (s_axi_awvalid && s_axi_awready) begin
         s_axi_awready <= 1'b0;
         aw_have_q     <= 1'b1;
         waddr_q       <= word_addr_ok(s_axi_awaddr) ? s_axi_awaddr[3:0] : 4'h1;
      end else if (aw_have_q && w_have_q && !s_axi_bvalid) begin
         aw_have_q     <= 1'b0;
      end else if (!aw_have_q && !s_axi_bvalid) begin
         s_axi_awready <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_wready <= 1'b0;
         w_have_q     <= 1'b0;
         wdata_q      <= 32'h00000000;
         wstrb_q      <= 4'h0;
      end else if (s_axi_wvalid && s_axi_wready) begin
         s_axi_wready <= 1'b0;
         w_have_q     <= 1'b1;
         wdata_q      <= s_axi_wdata;
         wstrb_q      <= s_axi_wstrb;
      end else if (aw_have_q && w_have_q && !s_axi_bvalid) begin
         w_have_q     <= 1'b0;
      end else if (!w_have_q && !s_axi_bvalid) begin
         s_axi_wready <= 1'b1;
      end
   end

   // Response only after both halves, so address and data may come in any order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_bvalid <= 1'b0;
         s_axi_bresp  <= ssg_pkg::RESP_OKAY;
      end else if (aw_have_q && w_have_q && !s_axi_bvalid) begin
         s_axi_bvalid <= 1'b1;
         s_axi_bresp  <= mapped(waddr_q) ? ssg_pkg::RESP_OKAY : ssg_pkg::RESP_SLVERR;
      end else if (s_axi_bready) begin
         s_axi_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         ready_mode_q <= ssg_pkg::CTRL_RESET;
         speed_cmd_q  <= ssg_pkg::SPEED_CMD_RESET;
      end else if (aw_have_q && w_have_q && !s_axi_bvalid) begin
         if (waddr_q == ssg_pkg::REG_CTRL && wstrb_q[0]) begin
            ready_mode_q <= wdata_q[ssg_pkg::CTRL_READY_MODE];
         end
         if (waddr_q == ssg_pkg::REG_SPEED_CMD) begin
            if (wstrb_q[0]) begin
               speed_cmd_q[7:0] <= wdata_q[7:0];
            end
            if (wstrb_q[1]) begin
               speed_cmd_q[15:8] <= wdata_q[15:8];
            end
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // AXI4-Lite read channel
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b0;
         s_axi_rdata   <= 32'h00000000;
         s_axi_rresp   <= ssg_pkg::RESP_OKAY;
      end else if (s_axi_arvalid && s_axi_arready) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid  <= 1'b1;
         s_axi_rresp   <= word_addr_ok(s_axi_araddr) ? ssg_pkg::RESP_OKAY : ssg_pkg::RESP_SLVERR;
         s_axi_rdata   <= 32'h00000000;
         if (word_addr_ok(s_axi_araddr)) begin
            case (s_axi_araddr[3:0])
               ssg_pkg::REG_CTRL: begin
                  s_axi_rdata[ssg_pkg::CTRL_READY_MODE] <= ready_mode_q;
               end
               ssg_pkg::REG_SPEED_CMD: begin
                  s_axi_rdata[15:0] <= speed_cmd_q;
               end
               ssg_pkg::REG_STATUS: begin
                  s_axi_rdata[ssg_pkg::ST_CONTACTOR_OFF] <= contactor_off;
                  s_axi_rdata[ssg_pkg::ST_EXCITATION]    <= excitation;
                  s_axi_rdata[ssg_pkg::ST_ORIENT_HOLD]   <= orient_hold;
                  s_axi_rdata[ssg_pkg::ST_ORIENT_DONE]   <= orient_done;
                  s_axi_rdata[ssg_pkg::ST_ORIENT_BUSY]   <= orient_busy_q;
                  s_axi_rdata[ssg_pkg::ST_STATE_LSB +: 2] <= st_q;
               end
               ssg_pkg::REG_SPEED: begin
                  s_axi_rdata[15:0] <= motor_speed;
               end
               default: begin
                  s_axi_rdata <= 32'h00000000;
               end
            endcase
         end
      end else if (s_axi_rvalid && s_axi_rready) begin
         s_axi_rvalid  <= 1'b0;
      end else if (!s_axi_rvalid) begin
         s_axi_arready <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Enable gating
   // RULE6: ready ignored in mode zero
   assign gate_ok    = !ready_mode_q || machine_ready;
   // RULE1: operable needs stop high
   assign operable   = emergency_stop_n && gate_ok;
   assign speed_zero = (motor_speed == 16'h0000);

   always_comb begin
      st_d = st_q;
      case (st_q)
         ssg_pkg::SSG_OFF: begin
            // RULE4: release makes rotatable
            if (emergency_stop_n) begin
               st_d = ssg_pkg::SSG_RUN;
            end
         end
         ssg_pkg::SSG_RUN: begin
            // RULE3: decelerate before contactor off
            if (!emergency_stop_n) begin
               st_d = speed_zero ? ssg_pkg::SSG_OFF : ssg_pkg::SSG_DECEL;
            end
         end
         ssg_pkg::SSG_DECEL: begin
            if (speed_zero) begin
               st_d = ssg_pkg::SSG_OFF;
            end
         end
         default: begin
            st_d = ssg_pkg::SSG_OFF;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q          <= ssg_pkg::SSG_OFF;
         contactor_off <= 1'b1;
      end else begin
         st_q          <= st_d;
         // RULE2: contactor off only in the off state, kept on through decel
         contactor_off <= (st_d == ssg_pkg::SSG_OFF);
      end
   end

   // Excitation kept through decel while gate_ok, so the stop is braked, not coasted
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         excitation <= 1'b0;
      end else begin
         // RULE7: ready low cuts excitation
         // Next state, so the run-to-decel edge leaves no one-cycle gap
         excitation <= ((st_d == ssg_pkg::SSG_RUN) && operable) ||
                       ((st_d == ssg_pkg::SSG_DECEL) && gate_ok);
      end
   end

   // RULE4: exactly one rotation command (fwd xor rev) starts
   assign target = ((st_q == ssg_pkg::SSG_RUN) && operable && !orient_busy_q &&
                    !orient_hold && (rotate_fwd ^ rotate_rev)) ? speed_cmd_q : 16'h0000;

   ssg_tick #(
      .DIV (TICK_DIV)
   ) u_tick (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick)
   );

   ssg_ramp #(
      .W (ssg_pkg::SPEED_W)
   ) u_ramp (
      .aclk    (aclk),
      .aresetn (aresetn),
      .tick    (tick),
      .target  (target),
      .speed_q (motor_speed)
   );

   ////////////////////////////////////////////////////////////////////////
   // Orientation
   // RULE10: move only while not already done
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         orient_busy_q <= 1'b0;
         orient_cnt_q  <= 16'h0000;
      end else if (!orientation_command || !operable || st_q != ssg_pkg::SSG_RUN) begin
         orient_busy_q <= 1'b0;
         orient_cnt_q  <= 16'h0000;
      end else if (orient_busy_q) begin
         orient_cnt_q  <= orient_cnt_q + 16'h0001;
         if (orient_cnt_q == 16'(ORIENT_CYC - 1)) begin
            orient_busy_q <= 1'b0;
         end
      end else if (!orient_done) begin
         orient_busy_q <= 1'b1;
         orient_cnt_q  <= 16'h0000;
      end
   end

   // Done survives ready toggling; only the command or a stop clears it
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         orient_done <= 1'b0;
      end else if (!orientation_command || !emergency_stop_n) begin
         orient_done <= 1'b0;
      end else if (orient_busy_q && orient_cnt_q == 16'(ORIENT_CYC - 1) && operable) begin
         orient_done <= 1'b1;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         orient_hold <= 1'b0;
      end else if (!orientation_command || !emergency_stop_n) begin
         orient_hold <= 1'b0;
      // RULE8: ready low releases hold
      end else if (!gate_ok) begin
         orient_hold <= 1'b0;
      // RULE9: ready high re-enters hold
      end else if (orient_done || (orient_busy_q && orient_cnt_q == 16'(ORIENT_CYC - 1))) begin
         orient_hold <= 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks
   sequence stop_while_turning;
      (st_q == ssg_pkg::SSG_RUN) && !emergency_stop_n && !speed_zero;
   endsequence

   sequence unclamp_release;
      ready_mode_q && orient_hold && !machine_ready;
   endsequence

   run_needs_stop_a: assert property ($rose(excitation) |-> $past(emergency_stop_n)) // RULE1
      else $error("excitation rose without stop input high");
   stop_off_a: assert property (!emergency_stop_n && speed_zero && !contactor_off
                                |-> ##[1:2] contactor_off) // RULE2
      else $error("contactor off late while stopped");
   decel_first_a: assert property (stop_while_turning |=> !contactor_off && excitation == gate_ok) // RULE3
      else $error("contactor off before motor stopped");
   off_at_zero_a: assert property ($rose(contactor_off) |-> $past(speed_zero)) // RULE3
      else $error("contactor off while turning");
   restart_a: assert property ((st_q == ssg_pkg::SSG_OFF) && emergency_stop_n
                               |=> !contactor_off && (st_q == ssg_pkg::SSG_RUN)) // RULE4
      else $error("no restart after stop release");
   mode_zero_a: assert property (!ready_mode_q && emergency_stop_n && (st_q == ssg_pkg::SSG_RUN)
                                 |=> excitation) // RULE6
      else $error("ready input not ignored in mode zero");
   ready_cut_a: assert property (ready_mode_q && !machine_ready |=> !excitation) // RULE7
      else $error("excitation kept with ready low");
   hold_release_a: assert property (unclamp_release |=> !orient_hold) // RULE8
      else $error("hold not released on ready low");
   hold_reenter_a: assert property (unclamp_release ##1 (machine_ready && ready_mode_q &&
                                    orientation_command && emergency_stop_n && orient_done)
                                    |=> orient_hold) // RULE9
      else $error("hold not re-entered on ready high");
   no_new_move_a: assert property (orient_done && orientation_command |=> !$rose(orient_busy_q)) // RULE10
      else $error("new orientation move during unclamp");
endmodule // ssg_gate
`default_nettype wire

// ### hw/ssg_pkg.sv
/*
 Constants, states and register map of the spindle stop and ready gate.
 Assumes a single 40 MHz clock and an AXI4-Lite register bus.
*/
// Behaviour
// RULE1: Operable only while emergency stop input high
// RULE2: Stop input low: contactor off, motor held
// RULE3: Stop while turning: ramp down, then contactor off
// RULE4: Stop released: rotate on any rotation command (the gate rotates only while exactly one of rotate_fwd and rotate_rev is high)
// RULE5: Controller clears commands when asserting stop (the model clears only rotate_fwd and rotate_rev, not orientation_command)
// RULE6: Ready mode zero ignores machine ready input
// RULE7: Ready mode one: machine ready low removes excitation
// RULE8: Machine ready low releases orientation hold
// RULE9: Machine ready high again re-enters orientation hold
// RULE10: Ready toggling never starts a new orientation
package ssg_pkg;
   localparam int unsigned CLK_PERIOD_NS  = 25;
   localparam int unsigned ORIENT_TIME_NS = 100000;
   localparam int unsigned ORIENT_CYC     = ORIENT_TIME_NS / CLK_PERIOD_NS;
   localparam int unsigned RAMP_TICK_NS   = 1000;
   localparam int unsigned RAMP_TICK_CYC  = RAMP_TICK_NS / CLK_PERIOD_NS;
   localparam int unsigned SPEED_W        = 16;
   localparam logic [15:0] RAMP_STEP      = 16'h0001;

   localparam logic [3:0] REG_CTRL      = 4'h0;
   localparam logic [3:0] REG_SPEED_CMD = 4'h4;
   localparam logic [3:0] REG_STATUS    = 4'h8;
   localparam logic [3:0] REG_SPEED     = 4'hc;

   localparam int unsigned CTRL_READY_MODE = 0;
   localparam logic        CTRL_RESET      = 1'b0;
   localparam logic [15:0] SPEED_CMD_RESET = 16'h0000;

   localparam int unsigned ST_CONTACTOR_OFF = 0;
   localparam int unsigned ST_EXCITATION    = 1;
   localparam int unsigned ST_ORIENT_HOLD   = 2;
   localparam int unsigned ST_ORIENT_DONE   = 3;
   localparam int unsigned ST_ORIENT_BUSY   = 4;
   localparam int unsigned ST_STATE_LSB     = 5;

   localparam logic [1:0] RESP_OKAY   = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   typedef enum logic [1:0] {
      SSG_OFF   = 2'b00,
      SSG_RUN   = 2'b01,
      SSG_DECEL = 2'b10
   } ssg_state_t;
endpackage

// ### hw/ssg_tick.sv
/*
 Divider giving a one-cycle enable pulse every DIV clocks.
 Assumes the single system clock and synchronous low reset.
*/
`timescale 1ns/100ps
`default_nettype none
module ssg_tick #(
   parameter int unsigned DIV = ssg_pkg::RAMP_TICK_CYC
) (
   input  wire logic aclk,
   input  wire logic aresetn,
   output logic      tick
);
   if (DIV < 1 || DIV > 65535) begin : g_bad_div
      $error("ssg_tick: DIV out of range");
   end

   logic [15:0] cnt_q;

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b0;
      end else if (cnt_q == 16'(DIV - 1)) begin
         cnt_q <= 16'h0000;
         tick  <= 1'b1;
      end else begin
         cnt_q <= cnt_q + 16'h0001;
         tick  <= 1'b0;
      end
   end
endmodule // ssg_tick
`default_nettype wire

// ### hw/ssg_ramp.sv
/*
 Speed ramp: moves the speed one step toward the target on each tick.
 Assumes tick is a one-cycle enable from the divider.
*/
`timescale 1ns/100ps
`default_nettype none
module ssg_ramp #(
   parameter int unsigned W = ssg_pkg::SPEED_W
) (
   input  wire logic         aclk,
   input  wire logic         aresetn,
   input  wire logic         tick,
   input  wire logic [W-1:0] target,
   output logic      [W-1:0] speed_q
);
   if (W < 2 || W > 16) begin : g_bad_w
      $error("ssg_ramp: W out of range");
   end

   localparam logic [W-1:0] STEP = W'(ssg_pkg::RAMP_STEP);

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         speed_q <= '0;
      end else if (tick) begin
         if (speed_q < target) begin
            speed_q <= (target - speed_q < STEP) ? target : speed_q + STEP;
         end else if (speed_q > target) begin
            speed_q <= (speed_q - target < STEP) ? target : speed_q - STEP;
         end
      end
   end
endmodule // ssg_ramp
`default_nettype wire

// ### testbench/ssg_ctrl_model.sv
/*
 Machine sequence controller model driving the spindle command pins.
 Assumes the bench sets the requested levels just after a rising edge.
*/
`timescale 1ns/100ps
`default_nettype none
module ssg_ctrl_model (
   input  wire logic aclk,
   input  wire logic req_stop_n,
   input  wire logic req_ready,
   input  wire logic req_orient,
   input  wire logic req_fwd,
   input  wire logic req_rev,
   output var logic  emergency_stop_n = 1'b0,
   output var logic  machine_ready = 1'b0,
   output var logic  orientation_command = 1'b0,
   output var logic  rotate_fwd = 1'b0,
   output var logic  rotate_rev = 1'b0
);
   ////////////////////////////////////////////////////////////////////////
   always @(posedge aclk) begin
      emergency_stop_n    <= req_stop_n;
      machine_ready       <= req_ready;
      orientation_command <= req_orient;
      rotate_fwd          <= req_fwd & req_stop_n;
      rotate_rev          <= req_rev & req_stop_n;
   end
endmodule // ssg_ctrl_model
`default_nettype wire

// ### testbench/testbench.sv
/*
 Self-checking bench for the spindle stop and ready gate.
 Assumes the controller model and the AXI4-Lite tasks below.
*/
`timescale 1ns/100ps
`default_nettype none
module testbench;
   typedef struct {
      logic [31:0] addr;
      logic        we;
      logic [31:0] wdata;
      logic [31:0] exp;
      logic [1:0]  resp;
   } ssg_row_t;
   logic aclk = 1'b0, aresetn = 1'b0;
   logic [31:0] awaddr = '0, wdata = '0, araddr = '0, rdata;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic awready, wready, bvalid, arready, rvalid;
   logic [3:0]  wstrb = 4'hf;
   logic [1:0]  bresp, rresp, r;
   logic [31:0] d;
   logic s_n = 1'b0, rdy = 1'b0, ori = 1'b0, fwd = 1'b0, rev = 1'b0;
   logic estop_n, mrdy, ocmd, rfwd, rrev, coff, exc, hold, done;
   logic [15:0] speed;
   int n_mismatch = 0, compares = 0, cyc = 0, i;
   ssg_row_t rows [6] = '{
      '{32'h0, 1'b0, 32'h0, 32'h0, 2'h0}, '{32'h4, 1'b0, 32'h0, 32'h0, 2'h0},
      '{32'h4, 1'b1, 32'h10, 32'h0, 2'h0}, '{32'h4, 1'b0, 32'h0, 32'h10, 2'h0},
      '{32'h10, 1'b1, 32'h1, 32'h0, 2'h2}, '{32'h10, 1'b0, 32'h0, 32'h0, 2'h2}};

   always #12.5 aclk = ~aclk;

   ssg_gate #(.ORIENT_CYC(8), .TICK_DIV(2)) dut_u (
      .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
      .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
      .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .emergency_stop_n(estop_n), .machine_ready(mrdy), .orientation_command(ocmd),
      .rotate_fwd(rfwd), .rotate_rev(rrev), .contactor_off(coff), .excitation(exc),
      .orient_hold(hold), .orient_done(done), .motor_speed(speed));

   ssg_ctrl_model ctrl_u (
      .aclk(aclk), .req_stop_n(s_n), .req_ready(rdy), .req_orient(ori), .req_fwd(fwd),
      .req_rev(rev), .emergency_stop_n(estop_n), .machine_ready(mrdy),
      .orientation_command(ocmd), .rotate_fwd(rfwd), .rotate_rev(rrev));

   ////////////////////////////////////////////////////////////////////////
   task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic print_verdict();
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // Long ceiling: whole run is a few hundred cycles
   always @(posedge aclk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         print_verdict();
      end
   end

   task automatic axi_wr(input logic [31:0] a, input logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      awaddr <= a; wdata <= v; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
      do begin
         @(posedge aclk);
         if (awvalid && awready === 1'b1) awvalid <= 1'b0;
         if (wvalid && wready === 1'b1) wvalid <= 1'b0;
      end while (bvalid !== 1'b1);
      rs = bresp;
      bready <= 1'b0;
   endtask

   task automatic axi_rd(input logic [31:0] a, output logic [31:0] v, output logic [1:0] rs);
      @(posedge aclk);
      araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
      do begin
         @(posedge aclk);
         if (arvalid && arready === 1'b1) arvalid <= 1'b0;
      end while (rvalid !== 1'b1);
      v = rdata; rs = rresp;
      rready <= 1'b0;
   endtask

   // Bounded wait on the ramp, never on a fixed count
   task automatic wait_speed(input logic [15:0] v);
      for (i = 0; i < 300 && speed !== v; i++) @(posedge aclk);
   endtask

   ////////////////////////////////////////////////////////////////////////
   initial begin
      repeat (10) @(posedge aclk);
      chk("coff_in_reset", coff, 1);
      chk("exc_in_reset", exc, 0);
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      repeat (5) @(posedge aclk);
      chk("coff_stop_low", coff, 1);
      chk("exc_stop_low", exc, 0);
      $display("test reset done");
      foreach (rows[k]) begin
         if (rows[k].we) axi_wr(rows[k].addr, rows[k].wdata, r);
         else axi_rd(rows[k].addr, d, r);
         chk("resp", {30'h0, r}, {30'h0, rows[k].resp});
         if (!rows[k].we) chk("rdata", d, rows[k].exp);
      end
      $display("test registers done");
      s_n <= 1'b1;
      repeat (4) @(posedge aclk);
      chk("coff_released", coff, 0);
      chk("exc_mode0_unready", exc, 1);
      fwd <= 1'b1;
      wait_speed(16'h0010);
      chk("speed_up", speed, 16'h0010);
      s_n <= 1'b0;
      repeat (4) @(posedge aclk);
      chk("coff_while_decel", coff, 0);
      chk("still_turning", speed !== 16'h0, 1);
      wait_speed(16'h0000);
      repeat (3) @(posedge aclk);
      chk("coff_after_stop", coff, 1);
      fwd <= 1'b0;
      s_n <= 1'b1;
      repeat (8) @(posedge aclk);
      chk("no_spin_on_release", speed, 16'h0);
      rev <= 1'b1;
      repeat (8) @(posedge aclk);
      chk("spin_on_command", speed !== 16'h0, 1);
      rev <= 1'b0;
      wait_speed(16'h0000);
      $display("test stop sequence done");
      axi_wr(32'h0, 32'h1, r);
      repeat (3) @(posedge aclk);
      chk("exc_mode1_unready", exc, 0);
      rdy <= 1'b1;
      repeat (3) @(posedge aclk);
      chk("exc_mode1_ready", exc, 1);
      $display("test ready mode done");
      ori <= 1'b1;
      for (i = 0; i < 100 && done !== 1'b1; i++) @(posedge aclk);
      chk("oriented", hold, 1);
      rdy <= 1'b0;
      repeat (3) @(posedge aclk);
      chk("hold_released", hold, 0);
      chk("done_kept", done, 1);
      rdy <= 1'b1;
      // Three cycles is shorter than a move of eight
      repeat (3) @(posedge aclk);
      chk("hold_reentered", hold, 1);
      axi_rd(32'h8, d, r);
      chk("status_no_move", d, 32'h0000002e);
      $display("test unclamp done");
      print_verdict();
   end
endmodule // testbench
`default_nettype wire
